/* hdl/event_controller.sv */
// Two-stage event controller with AXI4-Lite register access
// Function
// - Software reroutes requests via assignment registers
// - Default wakeup, errors to 7; RTC, DMA0 to 8
// - Default DMA channels 1-4 to input 9
// - Default DMA 5-7 to 10, timers to 11
// - Default flags to 12; memory DMA, watchdog 13
// - Three 16-bit core registers, bit per event
// - Latch sets on event, clears on acceptance
// - Latch writes only where mask bit clear
// - Mask bit set allows service; supervisor access
// - Global enable gates general inputs
// - Pending tracks nested active events, read-only
// - Three 32-bit per-source system registers
// - System mask gates each peripheral request
// - Status shows live peripheral request level
// - Enabled request wakes idled core
// - Pending bits acknowledge general inputs
// - Rising edge latched after two cycles
// - Latch clears at pending; next edge queued
// - Pending at least three cycles after edge
// - Lower event number means higher priority
// - Nine nested general inputs, higher preempts
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module event_controller #(
  parameter int NUM_SRC = 24
) (
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  input  wire logic [NUM_SRC-1:0] periph_req_i,
  input  wire logic [6:0]         core_event_i,
  input  wire logic               accept_i,
  input  wire logic               return_i,
  input  wire logic [3:0]         return_lvl_i,
  input  wire logic               gie_set_i,
  input  wire logic               gie_clr_i,
  input  wire logic               idle_i,
  output logic                    offer_o,
  output logic [3:0]              offer_lvl_o,
  output logic [15:0]             pending_o,
  output logic [8:0]              gen_input_o,
  output logic                    wake_o,
  input  wire logic               awvalid_i,
  output logic                    awready_o,
  input  wire logic [7:0]         awaddr_i,
  input  wire logic [2:0]         awprot_i,
  input  wire logic               wvalid_i,
  output logic                    wready_o,
  input  wire logic [31:0]        wdata_i,
  input  wire logic [3:0]         wstrb_i,
  output logic                    bvalid_o,
  input  wire logic               bready_i,
  output logic [1:0]              bresp_o,
  input  wire logic               arvalid_i,
  output logic                    arready_o,
  input  wire logic [7:0]         araddr_i,
  input  wire logic [2:0]         arprot_i,
  output logic                    rvalid_o,
  input  wire logic               rready_i,
  output logic [31:0]             rdata_o,
  output logic [1:0]              rresp_o
);
  if (NUM_SRC < 1 || NUM_SRC > event_ctrl_pkg::MAX_SRC) begin : g_chk
    $error("event_controller: NUM_SRC out of range");
  end

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic [NUM_SRC-1:0] sync1;
    logic [NUM_SRC-1:0] sync2;
    logic [8:0]         gen_q;
    logic [8:0]         gen_prev;
    logic [8:0]         edge_q;
    logic [15:0]        latch;
    logic [15:0]        mask;
    logic [15:0]        pend;
    logic               gie;
    logic [31:0]        pmask;
    logic [31:0]        wake_en;
    logic [2:0][31:0]   asg;
    logic               offer;
    logic [3:0]         offer_lvl;
    logic               wake;
    logic               aw_have;
    logic               w_have;
    logic [7:0]         aw_addr;
    logic               aw_priv;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               aw_rdy;
    logic               w_rdy;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               ar_rdy;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [8:0] gen_req;
  logic       wake_req;

  // Lowest set index of a vector, found flag on top
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // --------------------------------------------------------------
  // System request stage
  // --------------------------------------------------------------
  request_router #(
    .NUM_SRC (NUM_SRC)
  ) u_router (
    .req_i     (st_r.sync2),
    .pmask_i   (st_r.pmask[NUM_SRC-1:0]),
    .wake_en_i (st_r.wake_en[NUM_SRC-1:0]),
    .assign_i  (st_r.asg),
    .idle_i    (idle_i),
    .gen_req_o (gen_req),
    .wake_o    (wake_req)
  );

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [31:0] rd;
    logic [15:0] sw;
    logic [15:0] elig;
    logic [8:0]  ack;
    logic [4:0]  top;
    logic [4:0]  cand;
    wv     = 32'h0000_0000;
    rd     = 32'h0000_0000;
    sw     = 16'h0000;
    elig   = 16'h0000;
    ack    = 9'h000;
    top    = 5'h00;
    cand   = 5'h00;
    st_nxt = st_r;

    // Request synchronisers and edge detection
    st_nxt.sync1    = periph_req_i;
    st_nxt.sync2    = st_r.sync1;
    st_nxt.gen_prev = st_r.gen_q;
    st_nxt.edge_q   = st_r.gen_q & ~st_r.gen_prev;

    // Global enable, set wins over clear
    if (gie_clr_i) begin
      st_nxt.gie = 1'b0;
    end
    if (gie_set_i) begin
      st_nxt.gie = 1'b1;
    end

    // Write channel capture
    if (awvalid_i && st_r.aw_rdy) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = awaddr_i;
      st_nxt.aw_priv = awprot_i[0];
    end
    if (wvalid_i && st_r.w_rdy) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = wdata_i;
      st_nxt.w_strb = wstrb_i;
    end
    if (st_r.bvalid && bready_i) begin
      st_nxt.bvalid = 1'b0;
    end

    // Register write, privileged only
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = event_ctrl_pkg::RESP_OKAY;
      wv = st_r.w_data;
      if (!st_r.aw_priv) begin
        st_nxt.bresp = event_ctrl_pkg::RESP_SLVERR;
      end else begin
        case ({st_r.aw_addr[7:2], 2'b00})
          event_ctrl_pkg::OFF_LATCH: begin
            wv = merge({16'h0000, st_r.latch}, st_r.w_data, st_r.w_strb);
            sw = wv[15:0];
            st_nxt.latch = (st_r.latch & st_r.mask) |
                           (sw & ~st_r.mask);
          end
          event_ctrl_pkg::OFF_MASK: begin
            wv = merge({16'h0000, st_r.mask}, st_r.w_data, st_r.w_strb);
            st_nxt.mask = wv[15:0];
          end
          event_ctrl_pkg::OFF_PMASK: begin
            st_nxt.pmask = merge(st_r.pmask, wv, st_r.w_strb);
          end
          event_ctrl_pkg::OFF_WAKE: begin
            st_nxt.wake_en = merge(st_r.wake_en, wv, st_r.w_strb);
          end
          event_ctrl_pkg::OFF_ASSIGN0: begin
            st_nxt.asg[0] = merge(st_r.asg[0], wv, st_r.w_strb);
          end
          event_ctrl_pkg::OFF_ASSIGN1: begin
            st_nxt.asg[1] = merge(st_r.asg[1], wv, st_r.w_strb);
          end
          event_ctrl_pkg::OFF_ASSIGN2: begin
            st_nxt.asg[2] = merge(st_r.asg[2], wv, st_r.w_strb);
          end
          event_ctrl_pkg::OFF_PEND,
          event_ctrl_pkg::OFF_STATUS: begin
            st_nxt.bresp = event_ctrl_pkg::RESP_OKAY;
          end
          default: begin
            st_nxt.bresp = event_ctrl_pkg::RESP_SLVERR;
          end
        endcase
      end
    end

    // Read channel
    if (st_r.rvalid && rready_i) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid_i && st_r.ar_rdy) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = event_ctrl_pkg::RESP_OKAY;
      case ({araddr_i[7:2], 2'b00})
        event_ctrl_pkg::OFF_LATCH:   rd = {16'h0000, st_r.latch};
        event_ctrl_pkg::OFF_MASK:    rd = {16'h0000, st_r.mask};
        event_ctrl_pkg::OFF_PEND:    rd = {16'h0000, st_r.pend};
        event_ctrl_pkg::OFF_PMASK:   rd = st_r.pmask;
        event_ctrl_pkg::OFF_STATUS:  rd = 32'(st_r.sync2);
        event_ctrl_pkg::OFF_WAKE:    rd = st_r.wake_en;
        event_ctrl_pkg::OFF_ASSIGN0: rd = st_r.asg[0];
        event_ctrl_pkg::OFF_ASSIGN1: rd = st_r.asg[1];
        event_ctrl_pkg::OFF_ASSIGN2: rd = st_r.asg[2];
        default: st_nxt.rresp = event_ctrl_pkg::RESP_SLVERR;
      endcase
      if (!arprot_i[0]) begin
        rd           = 32'h0000_0000;
        st_nxt.rresp = event_ctrl_pkg::RESP_SLVERR;
      end
      st_nxt.rdata = rd;
    end

    // Nesting: return releases, acceptance enters
    if (return_i) begin
      st_nxt.pend[return_lvl_i] = 1'b0;
    end
    if (accept_i && st_r.offer) begin
      st_nxt.pend[st_r.offer_lvl]  = 1'b1;
      st_nxt.latch[st_r.offer_lvl] = 1'b0;
    end

    // New events set latch bits, winning over clears
    st_nxt.latch = st_nxt.latch | {st_r.edge_q, 7'h00} |
                   {9'h000, core_event_i & event_ctrl_pkg::FIXED_EVENTS};

    // Pending rise acknowledges the general input
    ack = st_nxt.pend[15:7] & ~st_r.pend[15:7];
    st_nxt.gen_q = gen_req & ~ack;

    // Highest priority eligible event above the active level
    elig = st_nxt.latch & st_nxt.mask &
           {{9{st_nxt.gie}}, 7'h7f};
    top  = first_set(st_nxt.pend);
    cand = first_set(elig);
    st_nxt.offer     = cand[4] && (!top[4] || cand[3:0] < top[3:0]);
    st_nxt.offer_lvl = cand[3:0];
    st_nxt.wake      = wake_req;

    // Handshake readiness
    st_nxt.aw_rdy = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.w_rdy  = !st_nxt.w_have && !st_nxt.bvalid;
    st_nxt.ar_rdy = !st_nxt.rvalid;
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_r         <= '0;
      st_r.mask    <= event_ctrl_pkg::RST_MASK;
      st_r.pmask   <= event_ctrl_pkg::RST_PMASK;
      st_r.wake_en <= event_ctrl_pkg::RST_WAKE;
      st_r.asg[0]  <= event_ctrl_pkg::RST_ASSIGN0;
      st_r.asg[1]  <= event_ctrl_pkg::RST_ASSIGN1;
      st_r.asg[2]  <= event_ctrl_pkg::RST_ASSIGN2;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign offer_o     = st_r.offer;
  assign offer_lvl_o = st_r.offer_lvl;
  assign pending_o   = st_r.pend;
  assign gen_input_o = st_r.gen_q;
  assign wake_o      = st_r.wake;
  assign awready_o   = st_r.aw_rdy;
  assign wready_o    = st_r.w_rdy;
  assign bvalid_o    = st_r.bvalid;
  assign bresp_o     = st_r.bresp;
  assign arready_o   = st_r.ar_rdy;
  assign rvalid_o    = st_r.rvalid;
  assign rdata_o     = st_r.rdata;
  assign rresp_o     = st_r.rresp;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  logic [8:0] gen_rise;
  logic [4:0] top_now;
  assign gen_rise = st_r.gen_q & ~st_r.gen_prev;
  assign top_now  = first_set(st_r.pend);

  sequence s_write_go;
    st_r.aw_have && st_r.w_have && !st_r.bvalid;
  endsequence

  sequence s_latch_write_masked;
    s_write_go and (st_r.aw_priv &&
    ({st_r.aw_addr[7:2], 2'b00} == event_ctrl_pkg::OFF_LATCH));
  endsequence

  sequence s_quiet_edge;
    $rose(st_r.gen_q[0]) && !st_r.pend[7];
  endsequence

  a_edge_latch: assert property (
    gen_rise[0] |-> ##2 st_r.latch[7])
    else $error("general input edge not latched after two cycles");

  a_pend_latency: assert property (
    s_quiet_edge |-> !st_r.pend[7] [*3])
    else $error("pending set sooner than three cycles");

  a_accept_enter: assert property (
    (accept_i && st_r.offer) |=>
      st_r.pend[$past(st_r.offer_lvl)])
    else $error("accepted event not marked pending");

  a_return_clear: assert property (
    (return_i && !(accept_i && st_r.offer &&
      st_r.offer_lvl == return_lvl_i)) |=>
      !st_r.pend[$past(return_lvl_i)])
    else $error("return did not clear pending bit");

  a_offer_masked: assert property (
    st_r.offer |-> st_r.mask[st_r.offer_lvl] &&
                   st_r.latch[st_r.offer_lvl])
    else $error("offered event is masked or not latched");

  a_offer_gie: assert property (
    (st_r.offer && st_r.offer_lvl >= event_ctrl_pkg::GEN_BASE) |->
      st_r.gie)
    else $error("general event offered while globally disabled");

  a_nest_order: assert property (
    (st_r.offer && top_now[4]) |-> st_r.offer_lvl < top_now[3:0])
    else $error("offer not above active nesting level");

  a_latch_guard: assert property (
    s_latch_write_masked |=>
      ((st_r.latch & ~$past(st_r.latch) & $past(st_r.mask)) == 16'h0 ||
       $past(st_r.edge_q) != 9'h000 || $past(core_event_i) != 7'h00))
    else $error("latch write altered an unmasked bit");

  a_gen_masked: assert property (
    ((st_r.sync2 & st_r.pmask[NUM_SRC-1:0]) == '0) |=>
      st_r.gen_q == 9'h000)
    else $error("general input driven with no unmasked request");

  a_wake_req: assert property (
    (idle_i && (st_r.sync2 & st_r.wake_en[NUM_SRC-1:0]) != '0) |=>
      wake_o)
    else $error("enabled request did not wake idle core");

  a_write_resp: assert property (
    s_write_go |=> bvalid_o ##0 !awready_o && !wready_o)
    else $error("write not answered one cycle after capture");

endmodule

/* hdl/request_router.sv */
// Shared constants and the system request routing stage
package event_ctrl_pkg;
  // --------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------
  localparam logic [7:0]  OFF_LATCH   = 8'h00;
  localparam logic [7:0]  OFF_MASK    = 8'h04;
  localparam logic [7:0]  OFF_PEND    = 8'h08;
  localparam logic [7:0]  OFF_PMASK   = 8'h0c;
  localparam logic [7:0]  OFF_STATUS  = 8'h10;
  localparam logic [7:0]  OFF_WAKE    = 8'h14;
  localparam logic [7:0]  OFF_ASSIGN0 = 8'h18;
  localparam logic [7:0]  OFF_ASSIGN1 = 8'h1c;
  localparam logic [7:0]  OFF_ASSIGN2 = 8'h20;
  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic [31:0] RST_ASSIGN0 = 32'h1000_0000;
  localparam logic [31:0] RST_ASSIGN1 = 32'h3332_2221;
  localparam logic [31:0] RST_ASSIGN2 = 32'h6665_5444;
  localparam logic [15:0] RST_MASK    = 16'h0000;
  localparam logic [31:0] RST_PMASK   = 32'h0000_0000;
  localparam logic [31:0] RST_WAKE    = 32'h0000_0000;
  // --------------------------------------------------------------
  // Field layout and counts
  // --------------------------------------------------------------
  localparam int          NUM_GEN     = 9;
  localparam int          ASSIGN_W    = 4;
  localparam int          MAX_SRC     = 24;
  localparam logic [3:0]  GEN_BASE    = 4'h7;
  localparam logic [6:0]  FIXED_EVENTS = 7'h6f;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

`timescale 1ns/1ps
module request_router #(
  parameter int NUM_SRC = 24
) (
  input  wire logic [NUM_SRC-1:0] req_i,
  input  wire logic [NUM_SRC-1:0] pmask_i,
  input  wire logic [NUM_SRC-1:0] wake_en_i,
  input  wire logic [95:0]        assign_i,
  input  wire logic               idle_i,
  output logic [8:0]              gen_req_o,
  output logic                    wake_o
);
  if (NUM_SRC < 1 || NUM_SRC > event_ctrl_pkg::MAX_SRC) begin : g_chk
    $error("request_router: NUM_SRC out of range");
  end

  // ------------------------------------------------------------
  // Merge unmasked requests onto their assigned general inputs
  // ------------------------------------------------------------
  always_comb begin
    logic [3:0] tgt;
    tgt       = 4'h0;
    gen_req_o = 9'h000;
    for (int s = 0; s < NUM_SRC; s++) begin
      tgt = assign_i[s*event_ctrl_pkg::ASSIGN_W +: 4];
      if (req_i[s] && pmask_i[s] &&
          (int'(tgt) < event_ctrl_pkg::NUM_GEN)) begin
        gen_req_o[tgt] = 1'b1;
      end
    end
    wake_o = idle_i && ((req_i & wake_en_i) != '0);
  end
endmodule

/* testbench/core_pipeline_model.sv */
// Behavioural model of the processor core that takes offered events
`timescale 1ns/1ps
module core_pipeline_model (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       offer_i,
  input  wire logic       accept_en_i,
  input  wire logic [3:0] accept_dly_i,
  output logic            accept_o
);
  logic [3:0] wait_r;

  // --------------------------------------------------------------
  // Acceptance
  // --------------------------------------------------------------
  // Takes an offer once it has stood for the chosen number of cycles
  always_ff @(posedge mclk_i) begin
    if (reset_i || !offer_i || accept_o) begin
      wait_r   <= 4'h0;
      accept_o <= 1'b0;
    end else begin
      if (wait_r < 4'hf) begin
        wait_r <= wait_r + 4'h1;
      end
      accept_o <= accept_en_i && (wait_r >= accept_dly_i);
    end
  end
endmodule

/* testbench/tb_event_controller.sv */
// Self-checking testbench for the two-stage event controller
`timescale 1ns/1ps
module tb_event_controller;
  localparam int DEF_IN [24] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 2, 2, 2, 2,
                                 3, 3, 3, 4, 4, 4, 5, 5, 6, 6, 6};
  logic        mclk_i, reset_i, acc, ret, gset, gclr, idle, acc_en;
  logic        offer, wake;
  logic [23:0] preq;
  logic [6:0]  cev;
  logic [3:0]  ret_lvl, acc_dly, offer_lvl;
  logic [15:0] pend;
  logic [8:0]  gen;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          miscompares, n_checks, cnt;

  event_controller i_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .periph_req_i(preq),
    .core_event_i(cev), .accept_i(acc), .return_i(ret),
    .return_lvl_i(ret_lvl), .gie_set_i(gset), .gie_clr_i(gclr),
    .idle_i(idle), .offer_o(offer), .offer_lvl_o(offer_lvl),
    .pending_o(pend), .gen_input_o(gen), .wake_o(wake),
    .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
    .awprot_i(awprot), .wvalid_i(wvalid), .wready_o(wready),
    .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid),
    .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid),
    .arready_o(arready), .araddr_i(araddr), .arprot_i(arprot),
    .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata),
    .rresp_o(rresp));

  core_pipeline_model i_core (
    .mclk_i(mclk_i), .reset_i(reset_i), .offer_i(offer),
    .accept_en_i(acc_en), .accept_dly_i(acc_dly), .accept_o(acc));

  // --------------------------------------------------------------
  // Clock and watchdog
  // --------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (30000) @(posedge mclk_i);
    miscompares++;
    end_of_test();
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic end_of_test();
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits n edges, then settles to the falling edge for sampling
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        input logic [2:0] p, output logic [1:0] rr);
    logic ah, wh, ad, wd, bh;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge mclk_i);
    awaddr  <= a;
    awprot  <= p;
    wdata   <= v;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge mclk_i);
      ah = !ad && awready;
      wh = !wd && wready;
      @(posedge mclk_i);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      ad = ad | ah;
      wd = wd | wh;
    end while (!(ad && wd));
    do begin
      @(negedge mclk_i);
      bh = bvalid;
      rr = bresp;
      @(posedge mclk_i);
    end while (!bh);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [2:0] p,
                        output logic [31:0] v, output logic [1:0] rr);
    logic h;
    @(posedge mclk_i);
    araddr  <= a;
    arprot  <= p;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge mclk_i);
      h = arready;
      @(posedge mclk_i);
    end while (!h);
    arvalid <= 1'b0;
    do begin
      @(negedge mclk_i);
      h  = rvalid;
      v  = rdata;
      rr = rresp;
      @(posedge mclk_i);
    end while (!h);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [2:0] p = 3'b001,
                    input logic [1:0] er = event_ctrl_pkg::RESP_OKAY);
    logic [1:0] rr;
    axi_wr(a, v, p, rr);
    chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, rr});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rr;
    axi_rd(a, 3'b001, v, rr);
    chk($sformatf("reg %h", a), e, v);
    chk($sformatf("rresp %h", a), {30'h0, event_ctrl_pkg::RESP_OKAY},
        {30'h0, rr});
  endtask

  task automatic set_req(input logic [23:0] v);
    @(posedge mclk_i);
    preq <= v;
  endtask

  task automatic ret_ev(input logic [3:0] l);
    @(posedge mclk_i);
    ret     <= 1'b1;
    ret_lvl <= l;
    @(posedge mclk_i);
    ret     <= 1'b0;
  endtask

  // Parks the core, releases a level and clears latch and mask
  task automatic cleanup(input logic [3:0] l);
    @(posedge mclk_i);
    acc_en <= 1'b0;
    preq   <= 24'h0;
    tick(6);
    ret_ev(l);
    wr(event_ctrl_pkg::OFF_MASK, 32'h0);
    wr(event_ctrl_pkg::OFF_LATCH, 32'h0);
    tick(2);
    chk("pending", 32'h0, {16'h0, pend});
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {preq, cev, ret, ret_lvl, gset, gclr, idle, acc_en} = '0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
    {awprot, arprot, wdata, wstrb} = '0;
    acc_dly = 4'h0;
    miscompares = 0;
    n_checks = 0;
    reset_i = 1'b1;
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    // Reset values and refusals
    rdc(event_ctrl_pkg::OFF_LATCH, 32'h0);
    rdc(event_ctrl_pkg::OFF_MASK, 32'h0);
    rdc(event_ctrl_pkg::OFF_PEND, 32'h0);
    rdc(event_ctrl_pkg::OFF_PMASK, 32'h0);
    rdc(event_ctrl_pkg::OFF_WAKE, 32'h0);
    axi_rd(8'h24, 3'b001, d, r);
    chk("unmapped rresp", 32'h2, {30'h0, r});
    wr(event_ctrl_pkg::OFF_MASK, 32'hffff, 3'b000, 2'b10);
    rdc(event_ctrl_pkg::OFF_MASK, 32'h0);
    wr(event_ctrl_pkg::OFF_PEND, 32'hffff);
    rdc(event_ctrl_pkg::OFF_PEND, 32'h0);
    // Peripheral mask blocks routing, status still shows requests
    set_req(24'hff_ffff);
    tick(5);
    chk("gen_input", 32'h0, {23'h0, gen});
    rdc(event_ctrl_pkg::OFF_STATUS, 32'h00ff_ffff);
    set_req(24'h0);
    wr(event_ctrl_pkg::OFF_PMASK, 32'h00ff_ffff);
    // Default routing of every source
    for (int s = 0; s < 24; s++) begin
      set_req(24'h1 << s);
      tick(5);
      chk("gen_input", 32'h1 << DEF_IN[s], {23'h0, gen});
      rdc(event_ctrl_pkg::OFF_STATUS, 32'h1 << s);
      set_req(24'h0);
      tick(5);
    end
    set_req(24'h7f);
    tick(5);
    chk("merged gen_input", 32'h1, {23'h0, gen});
    // Reassignment of source 0 to the last general input, 8
    wr(event_ctrl_pkg::OFF_ASSIGN0, 32'h1000_0008);
    set_req(24'h1);
    tick(5);
    chk("rerouted gen_input", 32'h100, {23'h0, gen});
    wr(event_ctrl_pkg::OFF_ASSIGN0, event_ctrl_pkg::RST_ASSIGN0);
    set_req(24'h0);
    // Latch writes only where mask is clear
    rdc(event_ctrl_pkg::OFF_LATCH, 32'hbf80);
    wr(event_ctrl_pkg::OFF_LATCH, 32'h0);
    wr(event_ctrl_pkg::OFF_MASK, 32'h0200);
    wr(event_ctrl_pkg::OFF_LATCH, 32'h0600);
    rdc(event_ctrl_pkg::OFF_LATCH, 32'h0400);
    wr(event_ctrl_pkg::OFF_MASK, 32'h0);
    wr(event_ctrl_pkg::OFF_LATCH, 32'h0);
    rdc(event_ctrl_pkg::OFF_LATCH, 32'h0);
    // Global enable with a slow core
    acc_dly <= 4'h5;
    wr(event_ctrl_pkg::OFF_MASK, 32'h0800);
    axi_rd(event_ctrl_pkg::OFF_MASK, 3'b000, d, r);
    chk("user rdata", 32'h0, d);
    chk("user rresp", {30'h0, event_ctrl_pkg::RESP_SLVERR}, {30'h0, r});
    set_req(24'h1 << 16);
    tick(6);
    chk("offer no gie", 32'h0, {31'h0, offer});
    rdc(event_ctrl_pkg::OFF_LATCH, 32'h0800);
    @(posedge mclk_i);
    gset <= 1'b1;
    @(posedge mclk_i);
    gset <= 1'b0;
    tick(2);
    chk("offer gie", 32'h1, {31'h0, offer});
    chk("offer_lvl", 32'hb, {28'h0, offer_lvl});
    @(posedge mclk_i);
    gclr <= 1'b1;
    tick(1);
    chk("offer gie off", 32'h0, {31'h0, offer});
    @(posedge mclk_i);
    gset <= 1'b1;
    tick(1);
    chk("offer set wins", 32'h1, {31'h0, offer});
    @(posedge mclk_i);
    gset <= 1'b0;
    gclr <= 1'b0;
    @(posedge mclk_i);
    acc_en <= 1'b1;
    tick(10);
    chk("pending", 32'h0800, {16'h0, pend});
    cleanup(4'hb);
    // Prompt core, edge to pending latency
    acc_dly <= 4'h0;
    acc_en  <= 1'b1;
    wr(event_ctrl_pkg::OFF_MASK, 32'h0080);
    set_req(24'h2);
    do @(negedge mclk_i); while (gen[0] !== 1'b1);
    cnt = 0;
    do begin
      @(negedge mclk_i);
      cnt++;
    end while (pend[7] !== 1'b1);
    chk("pending latency ok", 32'h1, {31'h0, cnt >= 3});
    tick(2);
    rdc(event_ctrl_pkg::OFF_LATCH, 32'h0080);
    cleanup(4'h7);
    // Priority and nesting of core events
    wr(event_ctrl_pkg::OFF_MASK, 32'h0060);
    @(posedge mclk_i);
    cev <= 7'h60;
    @(posedge mclk_i);
    cev <= 7'h00;
    tick(3);
    chk("offer_lvl", 32'h5, {28'h0, offer_lvl});
    @(posedge mclk_i);
    acc_en <= 1'b1;
    tick(6);
    chk("pending", 32'h0020, {16'h0, pend});
    ret_ev(4'h5);
    tick(6);
    chk("pending", 32'h0040, {16'h0, pend});
    @(posedge mclk_i);
    cev <= 7'h20;
    @(posedge mclk_i);
    cev <= 7'h00;
    tick(6);
    chk("pending", 32'h0060, {16'h0, pend});
    ret_ev(4'h5);
    cleanup(4'h6);
    // Wakeup of an idled core
    wr(event_ctrl_pkg::OFF_WAKE, 32'h0001_0000);
    @(posedge mclk_i);
    idle <= 1'b1;
    preq <= 24'h1 << 17;
    tick(5);
    chk("wake", 32'h0, {31'h0, wake});
    set_req(24'h1 << 16);
    tick(5);
    chk("wake", 32'h1, {31'h0, wake});
    @(posedge mclk_i);
    idle <= 1'b0;
    tick(2);
    chk("wake", 32'h0, {31'h0, wake});
    end_of_test();
  end
endmodule
